/* File: include/lecc_map.svh */
`ifndef LECC_MAP_SVH
`define LECC_MAP_SVH

// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define LECC_ADDR_W 12
`define LECC_ADDR_LANE6_HOLD 12'h48E
`define LECC_ADDR_LANE7_HOLD 12'h48F
`define LECC_ADDR_LANE0_STAT 12'h490
`define LECC_ADDR_LANE1_STAT 12'h491

// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define LECC_HOLD_RST 3'h7
`define LECC_CNT_TERM 8'hFF
`define LECC_CNT_NEAR 8'hFE
`define LECC_ACTIVE_BIT 3
`define LECC_BIT_UNEXP_CTRL 2
`define LECC_BIT_NOT_IN_TABLE 1
`define LECC_BIT_BAD_DISP 0
`define LECC_LANES 4
`define LECC_KINDS 3

`endif

/* File: include/lecc_pkg.sv */
`include "lecc_map.svh"

package lecc_pkg;
    typedef logic [`LECC_LANES-1:0][`LECC_KINDS-1:0][7:0] lecc_cnt_bus_t;
    typedef logic [`LECC_LANES-1:0][`LECC_KINDS-1:0] lecc_flags_t;
    typedef logic [`LECC_ADDR_W-1:0] lecc_addr_t;

    typedef struct packed {
        lecc_cnt_bus_t cnt;
        lecc_flags_t tcr;
        logic [1:0][2:0] hold;
        logic [7:0] rdata;
    } lecc_state_t;
endpackage

/* File: hdl/lecc_bank.sv */
// Functional notes
// - Hold enable set: counter stops at 0xFF until user clears it.
// - Hold enable clear: counter rolls over from 0xFF to zero.
// - Field bit 2 unexpected control, bit 1 not-in-table, bit 0 disparity.
// - Hold fields reset to 0x7; reserved upper bits read zero.
// - Status bit 3 shows lane active: 0 soft reset, 1 enabled.
// - Status bits 2:0 flag terminal count reached; reset to zero.
`timescale 1ns/100ps
`include "lecc_map.svh"

module lecc_bank (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire lecc_pkg::lecc_addr_t reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire lecc_pkg::lecc_flags_t err_event,
    input wire lecc_pkg::lecc_flags_t cnt_clear,
    input wire logic [1:0] lane_active,
    output lecc_pkg::lecc_cnt_bus_t cnt_value,
    output lecc_pkg::lecc_flags_t terminal_reached
);
    import lecc_pkg::*;

    lecc_state_t state;
    lecc_state_t next_state;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    // Lanes 0 and 1 have no hold register here, so they keep the reset value
    function automatic logic [2:0] hold_of(input lecc_state_t s, input logic [1:0] ln);
        logic [2:0] h;
        h = `LECC_HOLD_RST;
        if (ln[1]) begin
            h = s.hold[ln[0]];
        end
        return h;
    endfunction

    function automatic logic [7:0] read_mux(input lecc_state_t s, input lecc_addr_t a, input logic [1:0] act);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            `LECC_ADDR_LANE6_HOLD: d = {5'h00, s.hold[0]};
            `LECC_ADDR_LANE7_HOLD: d = {5'h00, s.hold[1]};
            `LECC_ADDR_LANE0_STAT: d = {4'h0, act[0], s.tcr[0]};
            `LECC_ADDR_LANE1_STAT: d = {4'h0, act[1], s.tcr[1]};
            default: d = 8'h00;
        endcase
        return d;
    endfunction

    // Only the four bank registers answer; any other address reads zero
    function automatic logic is_mapped(input lecc_addr_t a);
        return a >= `LECC_ADDR_LANE6_HOLD && a <= `LECC_ADDR_LANE1_STAT;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [2:0] h;
        h = 3'h0;
        next_state = state;
        for (int ln = 0; ln < `LECC_LANES; ln++) begin
            h = hold_of(state, 2'(ln));
            for (int k = 0; k < `LECC_KINDS; k++) begin
                // Clear then count: an error in the clear cycle still counts as one
                if (cnt_clear[ln][k]) begin
                    next_state.cnt[ln][k] = 8'h00;
                    next_state.tcr[ln][k] = 1'b0;
                end
                if (err_event[ln][k]) begin
                    if (cnt_clear[ln][k]) begin
                        next_state.cnt[ln][k] = 8'h01;
                    end else if (state.cnt[ln][k] == `LECC_CNT_TERM) begin
                        if (h[k]) begin
                            next_state.cnt[ln][k] = `LECC_CNT_TERM;
                        end else begin
                            next_state.cnt[ln][k] = 8'h00;
                        end
                    end else begin
                        next_state.cnt[ln][k] = state.cnt[ln][k] + 8'h01;
                        if (state.cnt[ln][k] == `LECC_CNT_NEAR) begin
                            next_state.tcr[ln][k] = 1'b1;
                        end
                    end
                end
            end
        end
        // Software is trusted to write these only with the deserializer block in soft reset
        if (reg_wr && reg_addr == `LECC_ADDR_LANE6_HOLD) begin
            next_state.hold[0] = reg_wdata[2:0];
        end
        if (reg_wr && reg_addr == `LECC_ADDR_LANE7_HOLD) begin
            next_state.hold[1] = reg_wdata[2:0];
        end
        if (reg_rd) begin
            next_state.rdata = read_mux(state, reg_addr, lane_active);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state.cnt <= '0;
            state.tcr <= '0;
            state.hold <= {2{`LECC_HOLD_RST}};
            state.rdata <= 8'h00;
        // Clock enable low freezes every field, read data included
        end else if (ce) begin
            state <= next_state;
        end
    end

    assign reg_rdata = state.rdata;
    assign cnt_value = state.cnt;
    assign terminal_reached = state.tcr;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    genvar gl, gk;
    generate
        for (gl = 0; gl < `LECC_LANES; gl++) begin : g_lane
            // A function result cannot be bit-selected, so give each lane a named copy
            logic [2:0] lane_hold;
            assign lane_hold = hold_of(state, 2'(gl));
            for (gk = 0; gk < `LECC_KINDS; gk++) begin : g_kind
                a_hold_at_term: assert property (@(posedge clk) disable iff (!rst_b)
                    ce && err_event[gl][gk] && !cnt_clear[gl][gk] && state.cnt[gl][gk] == 8'hFF
                    && lane_hold[gk] |=> state.cnt[gl][gk] == 8'hFF && state.tcr[gl][gk])
                    else $error("held counter left terminal value");
                a_wrap_past_term: assert property (@(posedge clk) disable iff (!rst_b)
                    ce && err_event[gl][gk] && !cnt_clear[gl][gk] && state.cnt[gl][gk] == 8'hFF
                    && !lane_hold[gk] |=> state.cnt[gl][gk] == 8'h00)
                    else $error("rolling counter did not wrap");
                a_count_by_one: assert property (@(posedge clk) disable iff (!rst_b)
                    ce && err_event[gl][gk] && !cnt_clear[gl][gk] && state.cnt[gl][gk] != 8'hFF
                    |=> state.cnt[gl][gk] == $past(state.cnt[gl][gk]) + 8'h01)
                    else $error("counter did not step by one");
                a_flag_on_term: assert property (@(posedge clk) disable iff (!rst_b)
                    ce && err_event[gl][gk] && !cnt_clear[gl][gk] && state.cnt[gl][gk] == 8'hFE
                    |=> state.tcr[gl][gk] ##0 state.cnt[gl][gk] == 8'hFF)
                    else $error("reached flag missing at terminal count");
                a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_b)
                    state.tcr[gl][gk] && !(ce && cnt_clear[gl][gk]) |=> state.tcr[gl][gk])
                    else $error("reached flag dropped without clear");
                a_clear_drops: assert property (@(posedge clk) disable iff (!rst_b)
                    ce && cnt_clear[gl][gk] |=> !state.tcr[gl][gk]
                    && state.cnt[gl][gk] == {7'h00, $past(err_event[gl][gk])})
                    else $error("user clear did not reset counter and flag");
                a_idle_holds: assert property (@(posedge clk) disable iff (!rst_b)
                    !err_event[gl][gk] && !cnt_clear[gl][gk]
                    |=> $stable(state.cnt[gl][gk]) && $stable(state.tcr[gl][gk]))
                    else $error("counter moved without event or clear");
                a_flag_needs_term: assert property (@(posedge clk) disable iff (!rst_b)
                    $rose(state.tcr[gl][gk]) |-> state.cnt[gl][gk] == `LECC_CNT_TERM)
                    else $error("reached flag rose away from terminal count");
                a_term_has_flag: assert property (@(posedge clk) disable iff (!rst_b)
                    state.cnt[gl][gk] == `LECC_CNT_TERM |-> state.tcr[gl][gk])
                    else $error("counter at terminal value without reached flag");
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Register bus checks
    // ------------------------------------------------------------

    a_hold_write: assert property (@(posedge clk) disable iff (!rst_b)
        ce && reg_wr && reg_addr == `LECC_ADDR_LANE7_HOLD
        |=> state.hold[1] == $past(reg_wdata[2:0]))
        else $error("lane 7 hold field not written");
    a_hold_readback: assert property (@(posedge clk) disable iff (!rst_b)
        ce && reg_rd && reg_addr == `LECC_ADDR_LANE6_HOLD
        |=> reg_rdata == {5'h00, $past(state.hold[0])})
        else $error("lane 6 hold readback wrong");
    a_status_read: assert property (@(posedge clk) disable iff (!rst_b)
        ce && reg_rd && reg_addr == `LECC_ADDR_LANE1_STAT
        |=> reg_rdata == {4'h0, $past(lane_active[1]), $past(state.tcr[1])})
        else $error("lane 1 status readback wrong");
    a_lane6_write: assert property (@(posedge clk) disable iff (!rst_b)
        ce && reg_wr && reg_addr == `LECC_ADDR_LANE6_HOLD
        |=> state.hold[0] == $past(reg_wdata[2:0]))
        else $error("lane 6 hold field not written");
    a_lane7_readback: assert property (@(posedge clk) disable iff (!rst_b)
        ce && reg_rd && reg_addr == `LECC_ADDR_LANE7_HOLD
        |=> reg_rdata == {5'h00, $past(state.hold[1])})
        else $error("lane 7 hold readback wrong");
    a_lane0_status: assert property (@(posedge clk) disable iff (!rst_b)
        ce && reg_rd && reg_addr == `LECC_ADDR_LANE0_STAT
        |=> reg_rdata[`LECC_ACTIVE_BIT] == $past(lane_active[0]) && reg_rdata[2:0] == $past(state.tcr[0]))
        else $error("lane 0 status readback wrong");
    a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_b)
        ce && reg_rd && !is_mapped(reg_addr)
        |=> reg_rdata == 8'h00)
        else $error("unmapped read returned data");
    // A stray write must leave both hold fields alone
    a_unmapped_write: assert property (@(posedge clk) disable iff (!rst_b)
        ce && reg_wr && !is_mapped(reg_addr)
        |=> $stable(state.hold))
        else $error("unmapped write changed a hold field");
    a_status_write_ignored: assert property (@(posedge clk) disable iff (!rst_b)
        ce && reg_wr && (reg_addr == `LECC_ADDR_LANE0_STAT || reg_addr == `LECC_ADDR_LANE1_STAT)
        |=> $stable(state.hold))
        else $error("status write changed a hold field");
    a_read_stands: assert property (@(posedge clk) disable iff (!rst_b)
        !(ce && reg_rd) |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_b)
        reg_rdata[7:4] == 4'h0)
        else $error("reserved read bits not zero");
    a_hold_write_only: assert property (@(posedge clk) disable iff (!rst_b)
        !(ce && reg_wr) |=> $stable(state.hold))
        else $error("hold field changed without a write");

    // ------------------------------------------------------------
    // Clock enable
    // ------------------------------------------------------------
    a_frozen_ce: assert property (@(posedge clk) disable iff (!rst_b)
        !ce |=> $stable(state))
        else $error("state moved with clock enable low");
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/100ps
`include "lecc_map.svh"

module testbench;
    import lecc_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    lecc_addr_t reg_addr = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    lecc_flags_t err_event = '0;
    lecc_flags_t cnt_clear = '0;
    logic [1:0] lane_active = 2'h0;
    lecc_cnt_bus_t cnt_value;
    lecc_flags_t terminal_reached;
    int mismatches = 0;
    int n_compared = 0;

    always #2.5 clk = ~clk;

    lecc_bank dut (.clk(clk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .err_event(err_event),
        .cnt_clear(cnt_clear), .lane_active(lane_active), .cnt_value(cnt_value),
        .terminal_reached(terminal_reached));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Read data is registered, so it is settled by the next falling edge
    task automatic bus(input logic wr, input lecc_addr_t a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wr = wr;
        reg_rd = ~wr;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    endtask

    // Back-to-back pulses on one [lane][kind] event or clear line
    task automatic pulse(input int ln, input int k, input int n, input logic clr);
        repeat (n) begin
            @(negedge clk);
            if (clr) cnt_clear[ln][k] = 1'b1;
            else err_event[ln][k] = 1'b1;
        end
        @(negedge clk);
        err_event = '0;
        cnt_clear = '0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        bus(1'b0, `LECC_ADDR_LANE6_HOLD, 8'h00);
        check(reg_rdata, 8'h07);
        bus(1'b0, `LECC_ADDR_LANE7_HOLD, 8'h00);
        check(reg_rdata, 8'h07);
        bus(1'b0, `LECC_ADDR_LANE0_STAT, 8'h00);
        check(reg_rdata, 8'h00);
        bus(1'b0, 12'h400, 8'h00);
        check(reg_rdata, 8'h00);
    endtask

    // Lanes still in soft reset while hold fields change
    task automatic t_write;
        bus(1'b1, `LECC_ADDR_LANE6_HOLD, 8'hFD);
        bus(1'b1, 12'h400, 8'hFA);
        bus(1'b0, `LECC_ADDR_LANE6_HOLD, 8'h00);
        check(reg_rdata, 8'h05);
        bus(1'b1, `LECC_ADDR_LANE0_STAT, 8'hFF);
        bus(1'b0, `LECC_ADDR_LANE0_STAT, 8'h00);
        check(reg_rdata, 8'h00);
    endtask

    task automatic t_hold;
        lane_active = 2'h3;
        pulse(0, 2, 256, 1'b0);
        check(cnt_value[0][2], 8'hFF);
        check(cnt_value[0][1], 8'h00);
        check({7'h00, terminal_reached[0][2]}, 8'h01);
        bus(1'b0, `LECC_ADDR_LANE0_STAT, 8'h00);
        check(reg_rdata, 8'h0C);
        bus(1'b0, `LECC_ADDR_LANE1_STAT, 8'h00);
        check(reg_rdata, 8'h08);
        pulse(0, 2, 1, 1'b1);
        check(cnt_value[0][2], 8'h00);
        check({7'h00, terminal_reached[0][2]}, 8'h00);
    endtask

    // Lane 6 has bit 1 cleared, bit 0 still set
    task automatic t_wrap;
        pulse(2, 1, 255, 1'b0);
        check(cnt_value[2][1], 8'hFF);
        pulse(2, 1, 1, 1'b0);
        check(cnt_value[2][1], 8'h00);
        check({7'h00, terminal_reached[2][1]}, 8'h01);
        pulse(2, 0, 257, 1'b0);
        check(cnt_value[2][0], 8'hFF);
    endtask

    // Clock enable low: counters and read data stay put
    task automatic t_freeze;
        bus(1'b0, `LECC_ADDR_LANE6_HOLD, 8'h00);
        ce = 1'b0;
        pulse(1, 0, 3, 1'b0);
        bus(1'b0, `LECC_ADDR_LANE1_STAT, 8'h00);
        check(cnt_value[1][0], 8'h00);
        check(reg_rdata, 8'h05);
        ce = 1'b1;
        pulse(1, 0, 3, 1'b0);
        check(cnt_value[1][0], 8'h03);
    endtask

    // Lane 7 rolls its unexpected-control counter once bit 2 is cleared
    task automatic t_lane7;
        lane_active = 2'h0;
        bus(1'b1, `LECC_ADDR_LANE7_HOLD, 8'h03);
        bus(1'b0, `LECC_ADDR_LANE7_HOLD, 8'h00);
        check(reg_rdata, 8'h03);
        lane_active = 2'h3;
        pulse(3, 2, 257, 1'b0);
        check(cnt_value[3][2], 8'h01);
        check({7'h00, terminal_reached[3][2]}, 8'h01);
    endtask

    // Clear with an error in one cycle keeps that error; a mid-run reset restores defaults
    task automatic t_midreset;
        @(negedge clk);
        cnt_clear[2][0] = 1'b1;
        err_event[2][0] = 1'b1;
        @(negedge clk);
        cnt_clear = '0;
        err_event = '0;
        check(cnt_value[2][0], 8'h01);
        check({7'h00, terminal_reached[2][0]}, 8'h00);
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        check(cnt_value[3][2], 8'h00);
        check({7'h00, terminal_reached[3][2]}, 8'h00);
        bus(1'b0, `LECC_ADDR_LANE7_HOLD, 8'h00);
        check(reg_rdata, 8'h07);
        bus(1'b0, `LECC_ADDR_LANE6_HOLD, 8'h00);
        check(reg_rdata, 8'h07);
    endtask

    task automatic summarize;
        if (mismatches == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        t_reset;
        t_write;
        t_freeze;
        t_hold;
        t_wrap;
        t_lane7;
        t_midreset;
        summarize;
    end

    // About 1100 cycles expected; cut a hang well beyond that
    initial begin
        #20000;
        mismatches++;
        summarize;
    end
endmodule
